// ### src/ssw_pkg.sv
// Package: register map, field positions, reset values and carrier structs
package ssw_pkg;
   // Register addresses (byte addresses on the APB)
   localparam logic [15:0] ADDR_CTRL     = 16'h6106;
   localparam logic [15:0] ADDR_RANDOM   = 16'h6105;
   localparam logic [15:0] ADDR_STRAP    = 16'h6100;

   // Control register fields
   localparam int BIT_RSVD_HI    = 7;
   localparam int BIT_MASK       = 6;
   localparam int BIT_OVERLOAD   = 5;
   localparam int BIT_SW_EN      = 4;
   localparam int BIT_INRUSH_OFF = 3;
   localparam int BIT_RNG_RUN    = 2;
   localparam int BIT_RNG_READY  = 1;
   localparam int BIT_RSVD_LO    = 0;

   localparam logic [7:0] CTRL_RESET = 8'h41;
   localparam logic [7:0] CTRL_WMASK = 8'h5e;

   // Synchroniser depth for pad inputs
   localparam int SYNC_STAGES = 3;

   // Pad side
   typedef struct packed {
      logic secure_signal_in;
      logic port3_bit4;
      logic overload;
      logic host_powered;
   } ssw_pads_s;

   // Internal controls out
   typedef struct packed {
      logic secure_signal_int;
      logic port3_bit4_int;
      logic switch_on;
      logic inrush_limit_on;
      logic rng_force_run;
   } ssw_ctrl_s;
endpackage

// ### src/ssw_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pad inputs
`timescale 1ns/1ns
module ssw_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } ssw_sync_s;

   ssw_sync_s st;
   ssw_sync_s next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Only the second and third stages vote; the first is metastability guard
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.out[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.out;
endmodule

// ### src/ssw_rng.sv
// LFSR random source, stepping only while run is high, with a ready pulse per new byte
`timescale 1ns/1ns
module ssw_rng #(
   parameter int BYTE_CYCLES = 8
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Control
   input  wire logic       run,
   // Output
   output logic [7:0]      value,
   output logic            new_value
);
   typedef struct packed {
      logic [15:0] lfsr;
      logic [7:0]  cnt;
      logic [7:0]  value;
      logic        new_value;
   } ssw_rng_s;

   ssw_rng_s st;
   ssw_rng_s next_st;

   always_comb begin
      next_st = st;
      next_st.new_value = 1'b0;
      if (run) begin
         next_st.lfsr = {st.lfsr[14:0],
                         st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
         if (st.cnt == 8'(BYTE_CYCLES - 1)) begin
            next_st.cnt       = 8'h00;
            next_st.value     = st.lfsr[7:0];
            next_st.new_value = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '{lfsr: 16'hace1, cnt: 8'h00, value: 8'h00, new_value: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign value     = st.value;
   assign new_value = st.new_value;
endmodule

// ### src/ssw_top.sv
// Secure supply switch control register bank with APB slave
//
// Contract
// - Mask bit 6 low passes secure signal and port3 bit4 pads through.
// - Mask bit 6 high forces secure signal to 0, port3 bit4 to 1.
// - Enable bit 4 low keeps the secure supply switch off.
// - Enable bit 4 high turns the secure supply switch on.
// - Bit 5 reads 1 while the switch current limiter is engaged.
// - Bit 3 low applies the 100 mA inrush limit, high removes it.
// - In host-powered configurations bit 3 is ignored.
// - Register at 6106h; bits 7,0 read-only reset 0 and 1; bit 6 resets 1.
// - Power-down reset pin low holds the whole block in reset.
// - Bit 2 high keeps the random generator running; low leaves contactless unit control.
// - Bit 1 sets on new random value, clears when 6105h is read.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module ssw_top (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        power_down_reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pads and analogue status
   input  wire logic        secure_signal_in,
   input  wire logic        port3_bit4,
   input  wire logic        switch_overload,
   input  wire logic        host_powered,
   // Contactless unit request for the generator
   input  wire logic        contactless_unit_rng_run,
   // Controls to internal logic and switches
   output logic             secure_signal_int,
   output logic             port3_bit4_int,
   output logic             switch_on,
   output logic             inrush_limit_on,
   output logic             rng_running
);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset combine

   logic rst_any;
   ssw_pkg::ssw_pads_s pads_sync;
   logic [7:0] rng_value;
   logic rng_new;

   // pad reset
   // The pad is asynchronous; assertion acts at once, release is clock-aligned
   logic [1:0] pd_rel;
   always_ff @(posedge sys_clk or posedge sys_rst or negedge power_down_reset_n) begin
      if (sys_rst || !power_down_reset_n) begin
         pd_rel <= 2'b00;
      end else begin
         pd_rel <= {pd_rel[0], 1'b1};
      end
   end
   assign rst_any = sys_rst | ~pd_rel[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Pad synchronisers and random source

   ssw_sync #(
      .WIDTH(4)
   ) u_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (rst_any),
      .async_in ({secure_signal_in, port3_bit4, switch_overload, host_powered}),
      .sync_out (pads_sync)
   );

   ssw_rng u_rng (
      .sys_clk   (sys_clk),
      .sys_rst   (rst_any),
      .run       (rng_running),
      .value     (rng_value),
      .new_value (rng_new)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]        ctrl;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      ssw_pkg::ssw_ctrl_s outs;
   } ssw_top_s;

   ssw_top_s st;
   ssw_top_s next_st;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   logic access;
   logic wr_ctrl;
   logic rd_rand;
   logic [7:0] ctrl_view;

   always_comb begin
      next_st = st;
      access  = psel && penable && !st.pready;
      wr_ctrl = access && pwrite && hit(paddr, ssw_pkg::ADDR_CTRL) && pstrb[0];
      rd_rand = access && !pwrite && hit(paddr, ssw_pkg::ADDR_RANDOM);

      if (wr_ctrl) begin
         next_st.ctrl = (st.ctrl & ~ssw_pkg::CTRL_WMASK)
                      | (pwdata[7:0] & ssw_pkg::CTRL_WMASK);
      end
      if (rd_rand) begin
         next_st.ctrl[ssw_pkg::BIT_RNG_READY] = 1'b0;
      end
      if (rng_new) begin
         next_st.ctrl[ssw_pkg::BIT_RNG_READY] = 1'b1;
      end
      next_st.ctrl[ssw_pkg::BIT_OVERLOAD] = pads_sync.overload;
      next_st.ctrl[ssw_pkg::BIT_RSVD_HI] = ssw_pkg::CTRL_RESET[ssw_pkg::BIT_RSVD_HI];
      next_st.ctrl[ssw_pkg::BIT_RSVD_LO] = ssw_pkg::CTRL_RESET[ssw_pkg::BIT_RSVD_LO];

      ctrl_view = st.ctrl;

      // APB answer one cycle after the access phase begins
      next_st.pready  = access;
      next_st.pslverr = 1'b0;
      if (access) begin
         next_st.prdata = 32'h0000_0000;
         if (hit(paddr, ssw_pkg::ADDR_CTRL)) begin
            if (!pwrite) begin
               next_st.prdata = {24'h000000, ctrl_view};
            end
         end else if (hit(paddr, ssw_pkg::ADDR_RANDOM)) begin
            if (!pwrite) begin
               next_st.prdata = {24'h000000, rng_value};
            end
         end else if (hit(paddr, ssw_pkg::ADDR_STRAP)) begin
            if (!pwrite) begin
               next_st.prdata = {31'h00000000, pads_sync.host_powered};
            end
         end else begin
            next_st.pslverr = 1'b1;
         end
      end

      // Mask the pads so switching spikes do not reach internal logic
      if (st.ctrl[ssw_pkg::BIT_MASK]) begin
         next_st.outs.secure_signal_int = 1'b0;
         next_st.outs.port3_bit4_int    = 1'b1;
      end else begin
         next_st.outs.secure_signal_int = pads_sync.secure_signal_in;
         next_st.outs.port3_bit4_int    = pads_sync.port3_bit4;
      end
      next_st.outs.switch_on = st.ctrl[ssw_pkg::BIT_SW_EN];
      next_st.outs.inrush_limit_on = pads_sync.host_powered
                                   | ~st.ctrl[ssw_pkg::BIT_INRUSH_OFF];
      next_st.outs.rng_force_run = st.ctrl[ssw_pkg::BIT_RNG_RUN] | contactless_unit_rng_run;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge sys_clk or posedge rst_any) begin
      if (rst_any) begin
         st.ctrl    <= ssw_pkg::CTRL_RESET;
         st.prdata  <= 32'h0000_0000;
         st.pready  <= 1'b0;
         st.pslverr <= 1'b0;
         st.outs    <= '{secure_signal_int: 1'b0, port3_bit4_int: 1'b1, switch_on: 1'b0,
                         inrush_limit_on: 1'b1, rng_force_run: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign prdata            = st.prdata;
   assign pready            = st.pready;
   assign pslverr           = st.pslverr;
   assign secure_signal_int = st.outs.secure_signal_int;
   assign port3_bit4_int    = st.outs.port3_bit4_int;
   assign switch_on         = st.outs.switch_on;
   assign inrush_limit_on   = st.outs.inrush_limit_on;
   assign rng_running       = st.outs.rng_force_run;
endmodule

// ### tb/ssw_props.sv
// Checker: concurrent properties on the switch control block ports
`timescale 1ns/1ns
module ssw_props (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        power_down_reset_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Controls
   input wire logic        contactless_unit_rng_run,
   input wire logic        secure_signal_int,
   input wire logic        port3_bit4_int,
   input wire logic        switch_on,
   input wire logic        rng_running
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst || !power_down_reset_n);
   logic take;
   logic wctl;
   logic mapped;
   assign take = psel && penable && !pready;
   assign wctl = take && pwrite && pstrb[0] && paddr == ssw_pkg::ADDR_CTRL;
   assign mapped = paddr inside {ssw_pkg::ADDR_CTRL, ssw_pkg::ADDR_RANDOM, ssw_pkg::ADDR_STRAP};
   ////////////////////////////////////////////////////////////////////////////////
   AST_ANSWER: assert property (take |=> pready)
      else $error("access not answered");
   AST_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_UNMAPPED: assert property (take && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access without error");
   AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   AST_SWITCH: assert property (wctl |=> ##1 switch_on == $past(pwdata[4], 2))
      else $error("switch does not follow enable");
   AST_MASK: assert property (wctl && pwdata[6] |=> ##2 !secure_signal_int && port3_bit4_int)
      else $error("masked inputs not forced");
   AST_RNG_CU: assert property (contactless_unit_rng_run |=> rng_running)
      else $error("generator not running on unit request");
   AST_PD_RESET: assert property (disable iff (sys_rst) !power_down_reset_n |->
      !switch_on && !pready && port3_bit4_int)
      else $error("outputs active during pad reset");
   C_WRITE: cover property (wctl);
   C_ERR: cover property (pslverr);
   C_MASK: cover property (port3_bit4_int && !secure_signal_int);
endmodule

// ### tb/ssw_top_tb_top.sv
// Testbench: register access sequences against the switch control block
`timescale 1ns/1ns
module ssw_top_tb_top;
   localparam logic [15:0] CTL = ssw_pkg::ADDR_CTRL;
   logic        sys_clk = 1'b0;
   logic        sys_rst, power_down_reset_n, psel, penable, pwrite, pready, pslverr;
   logic        secure_signal_in, port3_bit4, switch_overload, host_powered;
   logic        contactless_unit_rng_run, secure_signal_int, port3_bit4_int;
   logic        switch_on, inrush_limit_on, rng_running, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [7:0]  rd;
   int          fail_count, samples_checked, cycles;
   ssw_top u_dut (
      .sys_clk                  (sys_clk),
      .sys_rst                  (sys_rst),
      .power_down_reset_n       (power_down_reset_n),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .paddr                    (paddr),
      .pwdata                   (pwdata),
      .pstrb                    (pstrb),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .secure_signal_in         (secure_signal_in),
      .port3_bit4               (port3_bit4),
      .switch_overload          (switch_overload),
      .host_powered             (host_powered),
      .contactless_unit_rng_run (contactless_unit_rng_run),
      .secure_signal_int        (secure_signal_int),
      .port3_bit4_int           (port3_bit4_int),
      .switch_on                (switch_on),
      .inrush_limit_on          (inrush_limit_on),
      .rng_running              (rng_running)
   );
   always #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Request held until the edge that samples pready
   task automatic apb(logic w, logic [15:0] a, logic [7:0] d, logic [3:0] s);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {secure_signal_in, port3_bit4, switch_overload, host_powered} = 4'h0;
      {sys_rst, power_down_reset_n, contactless_unit_rng_run} = 3'b110;
      {cycles, fail_count, samples_checked} = '0;
      settle(20);
      sys_rst <= 1'b0;
      apb(0, CTL, 8'h00, 4'hf);
      check("ctrl reset", rd, ssw_pkg::CTRL_RESET);
      apb(1, CTL, 8'hff, 4'hf);
      apb(0, CTL, 8'h00, 4'hf);
      check("ctrl ro bits", rd, 8'h5f);
      check("switch on", switch_on, 1'b1);
      check("inrush off", inrush_limit_on, 1'b0);
      check("rng run", rng_running, 1'b1);
      secure_signal_in <= 1'b1;
      switch_overload <= 1'b1;
      settle(8);
      check("sig masked", secure_signal_int, 1'b0);
      check("p34 masked", port3_bit4_int, 1'b1);
      apb(1, CTL, 8'h00, 4'hf);
      apb(0, CTL, 8'h00, 4'hf);
      check("ctrl overload", rd & 8'hfd, 8'h21);
      check("sig pass", secure_signal_int, 1'b1);
      check("p34 pass", port3_bit4_int, 1'b0);
      check("switch off", switch_on, 1'b0);
      check("inrush on", inrush_limit_on, 1'b1);
      switch_overload <= 1'b0;
      // Lane 0 strobe low leaves the register alone
      apb(1, CTL, 8'h10, 4'he);
      // The switch output lags the write by one edge
      settle(2);
      check("strobe off", switch_on, 1'b0);
      host_powered <= 1'b1;
      apb(1, CTL, 8'h08, 4'hf);
      settle(8);
      check("host inrush", inrush_limit_on, 1'b1);
      apb(0, ssw_pkg::ADDR_STRAP, 8'h00, 4'hf);
      check("strap host", rd, 8'h01);
      host_powered <= 1'b0;
      settle(8);
      check("inrush removed", inrush_limit_on, 1'b0);
      apb(1, CTL, 8'h04, 4'hf);
      settle(30);
      apb(0, CTL, 8'h00, 4'hf);
      check("ready set", rd & 8'h02, 8'h02);
      apb(1, CTL, 8'h00, 4'hf);
      contactless_unit_rng_run <= 1'b1;
      settle(2);
      check("unit run", rng_running, 1'b1);
      settle(30);
      contactless_unit_rng_run <= 1'b0;
      // Generator must be idle before the clear is checked, or it sets the flag again
      settle(4);
      check("unit stop", rng_running, 1'b0);
      apb(0, CTL, 8'h00, 4'hf);
      check("ready by unit", rd & 8'h02, 8'h02);
      apb(0, ssw_pkg::ADDR_RANDOM, 8'h00, 4'hf);
      apb(0, CTL, 8'h00, 4'hf);
      check("ready cleared", rd & 8'h02, 8'h00);
      apb(0, 16'h6200, 8'h00, 4'hf);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 8'h00);
      apb(1, ssw_pkg::ADDR_RANDOM, 8'hff, 4'hf);
      check("ro write err", err, 1'b0);
      apb(1, CTL, 8'h10, 4'hf);
      power_down_reset_n <= 1'b0;
      settle(3);
      check("pd switch", switch_on, 1'b0);
      power_down_reset_n <= 1'b1;
      settle(3);
      apb(0, CTL, 8'h00, 4'hf);
      check("pd ctrl", rd & 8'hfd, 8'h41);
      close_out();
   end
endmodule
bind ssw_top ssw_props u_props (
   .sys_clk                  (sys_clk),
   .sys_rst                  (sys_rst),
   .power_down_reset_n       (power_down_reset_n),
   .psel                     (psel),
   .penable                  (penable),
   .pwrite                   (pwrite),
   .paddr                    (paddr),
   .pwdata                   (pwdata),
   .pstrb                    (pstrb),
   .prdata                   (prdata),
   .pready                   (pready),
   .pslverr                  (pslverr),
   .contactless_unit_rng_run (contactless_unit_rng_run),
   .secure_signal_int        (secure_signal_int),
   .port3_bit4_int           (port3_bit4_int),
   .switch_on                (switch_on),
   .rng_running              (rng_running)
);
